// ===== inc/trim_defines.svh
// Constants for the offset and gain trim register bank.
// Assumes byte-wide register access on the device clock.
// Overview of operation
// - Bits 11:0 at 0x34c offset the B core on the first input with cal on.
// - Bits 11:0 at 0x34e offset the B core on the second input with cal on.
// - Both B-core offsets apply alike in dual- and single-channel operation.
// - In dual mode bits 4:0 at 0x350 and 0x351 trim A-core banks 0 and 1.
// - In dual mode bits 4:0 at 0x352 and 0x353 trim B-core banks 0 and 1.
// - In single mode bits 4:0 at 0x354 trim A-core bank 0, apart from dual.
// - Each register loads a fuse value at power-up; writes may overwrite it.
`ifndef TRIM_DEFINES_SVH
`define TRIM_DEFINES_SVH
`define ADDR_W 12
`define ADDR_OFS_A_LO 12'h34c
`define ADDR_OFS_A_HI 12'h34d
`define ADDR_OFS_B_LO 12'h34e
`define ADDR_OFS_B_HI 12'h34f
`define ADDR_GAIN_A0_DUAL 12'h350
`define ADDR_GAIN_A1_DUAL 12'h351
`define ADDR_GAIN_B0_DUAL 12'h352
`define ADDR_GAIN_B1_DUAL 12'h353
`define ADDR_GAIN_A0_SINGLE 12'h354
`define RST_OFS 16'h0000
`define RST_GAIN 8'h00
`define OFS_MSB 11
`define GAIN_MSB 4
`define BYTE_W 8
`define LO_BYTE 7:0
`define HI_BYTE 15:8
`define N_GAIN 5
`define N_OFS_BYTE 4
`define SEL_OFS_A_LO 0
`define SEL_OFS_A_HI 1
`define SEL_OFS_B_LO 2
`define SEL_OFS_B_HI 3
`define IDX_A0_DUAL 0
`define IDX_A1_DUAL 1
`define IDX_B0_DUAL 2
`define IDX_B1_DUAL 3
`define IDX_A0_SINGLE 4
`define OFS_ZERO 12'h000
`define RDATA_IDLE 8'h00
`endif

// ===== inc/trim_pkg.sv
// Types shared by the trim register bank.
// Assumes the defines header is compiled alongside.
`default_nettype none
package trim_pkg;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
	} reg_req_t;
	typedef struct packed {
		logic [11:0] ofs_a;
		logic [11:0] ofs_b;
		logic [4:0] gain_a0;
		logic [4:0] gain_a1;
		logic [4:0] gain_b0;
		logic [4:0] gain_b1;
	} trim_out_t;
	typedef enum logic [0:0] {FUSE_WAIT, RUN} load_state_t;
endpackage
`default_nettype wire

// ===== core/trim_regs.sv
// Offset and fine gain trim register bank with fuse preload.
// Assumes a byte-wide register port in the clk_i domain and fuse data that
// is stable while fuse_valid_i is high.
`timescale 1ns/100ps
`default_nettype none
`include "trim_defines.svh"

module trim_regs (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register port.
	input wire trim_pkg::reg_req_t req_i,
	output logic [7:0] rdata_o,
	// Fuse storage.
	input wire logic fuse_valid_i,
	input wire logic [15:0] fuse_ofs_a_i,
	input wire logic [15:0] fuse_ofs_b_i,
	input wire logic [39:0] fuse_gain_i,
	// Operating mode.
	input wire logic fg_cal_en_i,
	input wire logic single_mode_i,
	// Trim values to the converter cores.
	output trim_pkg::trim_out_t trim_o
);
	// Register contents, reserved bits included.
	logic [15:0] ofs_a;
	logic [15:0] ofs_b;
	logic [`BYTE_W-1:0] gain [0:`N_GAIN-1];
	// Load sequencing.
	trim_pkg::load_state_t state;
	logic fuse_s1;
	logic fuse_s2;
	logic fuse_load;
	// Address decode.
	logic [`N_OFS_BYTE-1:0] ofs_rd_hit;
	logic [`N_OFS_BYTE-1:0] ofs_wr_hit;
	logic [`N_GAIN-1:0] gain_rd_hit;
	logic [`N_GAIN-1:0] gain_wr_hit;
	// Next values of the output flops.
	logic [7:0] next_rdata;
	trim_pkg::trim_out_t next_trim;

	// One decode serves writes and reads, so the two can never disagree on
	// which offset byte an address names.
	function automatic logic [`N_OFS_BYTE-1:0] ofs_hit(
		input logic [`ADDR_W-1:0] addr
	);
		logic [`N_OFS_BYTE-1:0] hit;
		hit = '0;
		case (addr)
			`ADDR_OFS_A_LO:
				hit[`SEL_OFS_A_LO] = 1'b1;
			`ADDR_OFS_A_HI:
				hit[`SEL_OFS_A_HI] = 1'b1;
			`ADDR_OFS_B_LO:
				hit[`SEL_OFS_B_LO] = 1'b1;
			`ADDR_OFS_B_HI:
				hit[`SEL_OFS_B_HI] = 1'b1;
			default:
				hit = '0;
		endcase
		return hit;
	endfunction

	// Gain registers sit at consecutive byte addresses from the first one.
	function automatic logic [`N_GAIN-1:0] gain_hit(
		input logic [`ADDR_W-1:0] addr
	);
		logic [`N_GAIN-1:0] hit;
		hit = '0;
		for (int i = 0; i < `N_GAIN; i++)
		begin
			if (addr == `ADDR_GAIN_A0_DUAL + `ADDR_W'(i))
				hit[i] = 1'b1;
		end
		return hit;
	endfunction

	assign ofs_rd_hit = ofs_hit(req_i.addr);
	assign gain_rd_hit = gain_hit(req_i.addr);
	assign ofs_wr_hit = req_i.wr ? ofs_hit(req_i.addr) : '0;
	assign gain_wr_hit = req_i.wr ? gain_hit(req_i.addr) : '0;
	assign fuse_load = (state == trim_pkg::FUSE_WAIT) && fuse_s2;

	// Fuse readiness comes from another block, so it is synchronised first.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			fuse_s1 <= 1'b0;
			fuse_s2 <= 1'b0;
		end
		else
		begin
			fuse_s1 <= fuse_valid_i;
			fuse_s2 <= fuse_s1;
		end
	end

	// The load happens once per reset; later changes on the fuse inputs are
	// ignored so that they cannot undo trims that software has written.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			state <= trim_pkg::FUSE_WAIT;
		else
		begin
			case (state)
				trim_pkg::FUSE_WAIT:
				begin
					if (fuse_s2)
						state <= trim_pkg::RUN;
				end
				trim_pkg::RUN:
					state <= trim_pkg::RUN;
				default:
					state <= trim_pkg::FUSE_WAIT;
			endcase
		end
	end

	// A write in the load cycle is lost: the factory value wins that edge.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ofs_a <= `RST_OFS;
			ofs_b <= `RST_OFS;
		end
		else if (fuse_load)
		begin
			ofs_a <= fuse_ofs_a_i;
			ofs_b <= fuse_ofs_b_i;
		end
		else
		begin
			if (ofs_wr_hit[`SEL_OFS_A_LO])
				ofs_a[`LO_BYTE] <= req_i.wdata;
			if (ofs_wr_hit[`SEL_OFS_A_HI])
				ofs_a[`HI_BYTE] <= req_i.wdata;
			if (ofs_wr_hit[`SEL_OFS_B_LO])
				ofs_b[`LO_BYTE] <= req_i.wdata;
			if (ofs_wr_hit[`SEL_OFS_B_HI])
				ofs_b[`HI_BYTE] <= req_i.wdata;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `N_GAIN; g++)
		begin : gain_bank
			always_ff @(posedge clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
					gain[g] <= `RST_GAIN;
				else if (fuse_load)
					gain[g] <= fuse_gain_i[g*`BYTE_W +: `BYTE_W];
				else if (gain_wr_hit[g])
					gain[g] <= req_i.wdata;
			end
		end
	endgenerate

	// Unmapped addresses read as zero.
	always_comb
	begin
		next_rdata = `RDATA_IDLE;
		if (ofs_rd_hit[`SEL_OFS_A_LO])
			next_rdata = ofs_a[`LO_BYTE];
		else if (ofs_rd_hit[`SEL_OFS_A_HI])
			next_rdata = ofs_a[`HI_BYTE];
		else if (ofs_rd_hit[`SEL_OFS_B_LO])
			next_rdata = ofs_b[`LO_BYTE];
		else if (ofs_rd_hit[`SEL_OFS_B_HI])
			next_rdata = ofs_b[`HI_BYTE];
		for (int i = 0; i < `N_GAIN; i++)
		begin
			if (gain_rd_hit[i])
				next_rdata = gain[i];
		end
	end

	// Offsets are forced to zero when calibration is off so the cores never
	// add a stale correction; reserved bits are dropped here.
	always_comb
	begin
		next_trim.ofs_a = `OFS_ZERO;
		next_trim.ofs_b = `OFS_ZERO;
		if (fg_cal_en_i)
		begin
			next_trim.ofs_a = ofs_a[`OFS_MSB:0];
			next_trim.ofs_b = ofs_b[`OFS_MSB:0];
		end
		if (single_mode_i)
			next_trim.gain_a0 = gain[`IDX_A0_SINGLE][`GAIN_MSB:0];
		else
			next_trim.gain_a0 = gain[`IDX_A0_DUAL][`GAIN_MSB:0];
		next_trim.gain_a1 = gain[`IDX_A1_DUAL][`GAIN_MSB:0];
		next_trim.gain_b0 = gain[`IDX_B0_DUAL][`GAIN_MSB:0];
		next_trim.gain_b1 = gain[`IDX_B1_DUAL][`GAIN_MSB:0];
	end

	// Read data costs one cycle of latency but leaves the pin glitch free.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rdata_o <= `RDATA_IDLE;
		else
			rdata_o <= next_rdata;
	end

	// Trim values change only on a clock edge or when reset asserts, which clears them at once.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			trim_o <= '0;
		else
			trim_o <= next_trim;
	end
endmodule
`default_nettype wire

// ===== tb/trim_regs_monitor.sv
// Checker for the trim register bank.
// Bound into trim_regs and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module trim_regs_monitor (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire trim_pkg::reg_req_t req_i,
	input wire logic [7:0] rdata_o,
	input wire logic fuse_valid_i,
	input wire logic [39:0] fuse_gain_i,
	input wire logic fg_cal_en_i,
	input wire logic single_mode_i,
	input wire trim_pkg::trim_out_t trim_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	ofs_a_gate_a: assert property (!fg_cal_en_i |=> !trim_o.ofs_a)
		else $error("ofs a ungated");
	ofs_b_gate_a: assert property (!fg_cal_en_i |=> !trim_o.ofs_b)
		else $error("ofs b ungated");
	ofs_mode_a: assert property ($rose(single_mode_i) && !$past(req_i.wr)
		&& $stable(fg_cal_en_i) |=> $stable(trim_o.ofs_b))
		else $error("ofs b moved");
	gain_a1_a: assert property (req_i.wr && req_i.addr == 12'h351
		|-> ##2 trim_o.gain_a1 == $past(req_i.wdata[4:0], 2))
		else $error("gain a1");
	gain_b0_a: assert property (req_i.wr && req_i.addr == 12'h352
		|-> ##2 trim_o.gain_b0 == $past(req_i.wdata[4:0], 2))
		else $error("gain b0");
	single_gain_a: assert property (req_i.wr && single_mode_i
		&& req_i.addr == 12'h354 ##1 single_mode_i
		|-> ##1 trim_o.gain_a0 == $past(req_i.wdata[4:0], 2))
		else $error("single gain");
	fuse_load_a: assert property ($rose(fuse_valid_i)
		|-> ##[3:5] trim_o.gain_b1 == fuse_gain_i[28:24])
		else $error("fuse load");
	read_back_a: assert property (req_i.wr && req_i.addr >= 12'h34c
		&& req_i.addr <= 12'h354
		##1 !req_i.wr && $stable(req_i.addr)
		|=> rdata_o == $past(req_i.wdata, 2))
		else $error("read back");
endmodule
bind trim_regs trim_regs_monitor u_mon (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .rdata_o(rdata_o),
	.fuse_valid_i(fuse_valid_i), .fuse_gain_i(fuse_gain_i),
	.fg_cal_en_i(fg_cal_en_i), .single_mode_i(single_mode_i),
	.trim_o(trim_o)
);
`default_nettype wire

// ===== tb/trim_regs_tb.sv
// Self-checking bench for the trim register bank.
// Inputs change on falling edges; fuse data is held by the bench.
`timescale 1ns/100ps
`default_nettype none
module trim_regs_tb;
	logic clk_i = 0;
	logic rst_b_i = 0;
	logic fuse_valid_i = 0;
	logic fg_cal_en_i = 1;
	logic single_mode_i = 0;
	trim_pkg::reg_req_t req_i = '0;
	logic [7:0] rdata_o;
	trim_pkg::trim_out_t trim_o;
	logic [15:0] fuse_ofs_a_i = 16'hf123;
	logic [15:0] fuse_ofs_b_i = 16'h0abc;
	logic [39:0] fuse_gain_i = 40'h1514131211;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	trim_regs u_dut (.clk_i, .rst_b_i, .req_i, .rdata_o, .fuse_valid_i,
		.fuse_ofs_a_i, .fuse_ofs_b_i, .fuse_gain_i, .fg_cal_en_i,
		.single_mode_i, .trim_o);
	initial forever #5 clk_i = ~clk_i;
	task automatic chk(input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_i) req_i = '{a, d, 1'b1};
		@(negedge clk_i) req_i.wr = 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(negedge clk_i) req_i.addr = a;
		@(negedge clk_i) chk(rdata_o, e);
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// The ceiling is well above the sixty or so cycles the tests need.
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			report_and_stop;
		end
	end
	initial
	begin
		repeat (3) @(negedge clk_i);
		rst_b_i = 1;
		@(negedge clk_i) fuse_valid_i = 1;
		repeat (6) @(negedge clk_i);
		chk(trim_o.gain_b1, 5'h14);
		rd(12'h34d, 8'hf1);
		for (int i = 0; i < 9; i++)
		begin
			wr(12'h34c + 12'(i), 8'he0 + 8'(i));
			rd(12'h34c + 12'(i), 8'he0 + 8'(i));
		end
		chk(trim_o.ofs_a, 12'h1e0);
		chk(trim_o.ofs_b, 12'h3e2);
		chk(trim_o.gain_a0, 5'h04);
		chk(trim_o.gain_a1, 5'h05);
		chk(trim_o.gain_b0, 5'h06);
		chk(trim_o.gain_b1, 5'h07);
		single_mode_i = 1;
		repeat (2) @(negedge clk_i);
		chk(trim_o.gain_a0, 5'h08);
		chk(trim_o.ofs_b, 12'h3e2);
		wr(12'h354, 8'h3a);
		rd(12'h354, 8'h3a);
		chk(trim_o.gain_a0, 5'h1a);
		fg_cal_en_i = 0;
		repeat (2) @(negedge clk_i);
		chk(trim_o.ofs_a, 12'h000);
		chk(trim_o.ofs_b, 12'h000);
		rd(12'h400, 8'h00);
		report_and_stop;
	end
endmodule
`default_nettype wire
